// ### rtl/agohp_top.sv
// Register bank and sample datapath: gain, offset, filter and lane patterns
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module agohp_top
  import agohp_pkg::*;
#(
  parameter int DEPTH = agohp_pkg::FIFO_DEPTH
) (
  input  wire logic                           sys_clk_in,
  input  wire logic                           reset_in,
  input  wire logic [agohp_pkg::ADDR_W-1:0]   avs_address_in,
  input  wire logic                           avs_read_in,
  input  wire logic                           avs_write_in,
  input  wire logic [agohp_pkg::DATA_W-1:0]   avs_writedata_in,
  input  wire logic [3:0]                     avs_byteenable_in,
  output logic      [agohp_pkg::DATA_W-1:0]   avs_readdata_out,
  output logic                                avs_waitrequest_out,
  input  wire logic [agohp_pkg::SAMPLE_W-1:0] sample_in,
  input  wire logic                           sample_valid_in,
  output logic                                sample_ready_out,
  output logic      [agohp_pkg::SAMPLE_W-1:0] lane1_out,
  output logic      [agohp_pkg::SAMPLE_W-1:0] lane2_out,
  output logic      [agohp_pkg::SAMPLE_W-1:0] lane3_out,
  output logic      [agohp_pkg::SAMPLE_W-1:0] lane4_out,
  output logic                                lane_valid_out,
  input  wire logic                           lane_ready_in
);
  import agohp_pkg::*;
  localparam int SW = SAMPLE_W;

  logic [15:0] reg_odd;
  logic [15:0] reg_even;
  logic [15:0] reg_pat;
  logic [2:0]  reg_global;
  agohp_bus_t  bus_state;
  logic [DATA_W-1:0] rdata;

  // Register bus: one wait cycle, answer in the second cycle
  wire bus_req   = avs_read_in || avs_write_in;
  wire bus_ack   = bus_req && (bus_state == BUS_DONE);
  wire wr_odd    = bus_ack && avs_write_in && avs_address_in == IDX_ODD;
  wire wr_even   = bus_ack && avs_write_in && avs_address_in == IDX_EVEN;
  wire wr_pat    = bus_ack && avs_write_in && avs_address_in == IDX_PAT;
  wire wr_glb    = bus_ack && avs_write_in && avs_address_in == IDX_GLOBAL;
  wire [15:0] wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [SW-1:0] fifo_out_data;
  logic out_full;

  always_comb
  begin
    rdata = '0;
    case (avs_address_in)
      IDX_ODD:    rdata = {16'h0000, reg_odd};
      IDX_EVEN:   rdata = {16'h0000, reg_even};
      IDX_PAT:    rdata = {16'h0000, reg_pat};
      IDX_GLOBAL: rdata = {29'h0, reg_global};
      IDX_STATUS: rdata = {30'h0, out_full, fifo_out_valid};
      default:    rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      bus_state           <= BUS_IDLE;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= '0;
    end
    else
    begin
      case (bus_state)
        BUS_IDLE: bus_state <= bus_req ? BUS_DONE : BUS_IDLE;
        BUS_DONE: bus_state <= BUS_IDLE;
        default:  bus_state <= BUS_IDLE;
      endcase
      avs_waitrequest_out <= !(bus_req && bus_state == BUS_IDLE);
      if (bus_req && bus_state == BUS_IDLE && avs_read_in)
        avs_readdata_out <= rdata;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      reg_odd    <= RESET_VAL;
      reg_even   <= RESET_VAL;
      reg_pat    <= RESET_VAL;
      reg_global <= '0;
    end
    else
    begin
      if (wr_odd)
        reg_odd <= merge(reg_odd, avs_writedata_in[15:0], wmask);
      if (wr_even)
        reg_even <= merge(reg_even, avs_writedata_in[15:0], wmask);
      if (wr_pat)
        reg_pat <= merge(reg_pat, avs_writedata_in[15:0], wmask);
      if (wr_glb && avs_byteenable_in[0])
        reg_global <= avs_writedata_in[2:0];
    end
  end

  wire gain_en = reg_global[GLB_GAIN_BIT];
  wire ofs_en  = reg_global[GLB_OFS_BIT];
  wire pat_en  = reg_global[GLB_PAT_BIT];

  // Input sample FIFO; sample_ready_out is its registered-state ready
  logic fifo_in_ready;
  agohp_fifo #(.WIDTH(SW), .DEPTH(DEPTH)) u_fifo (
    .sys_clk_in   (sys_clk_in),
    .reset_in     (reset_in),
    .wr_data_in   (sample_in),
    .wr_valid_in  (sample_valid_in),
    .wr_ready_out (fifo_in_ready),
    .rd_data_out  (fifo_out_data),
    .rd_valid_out (fifo_out_valid),
    .rd_ready_in  (fifo_out_ready)
  );
  assign sample_ready_out = fifo_in_ready;

  // Output register stage
  assign out_full       = lane_valid_out && !lane_ready_in;
  assign fifo_out_ready = !out_full;
  wire take = fifo_out_valid && fifo_out_ready;

  // Sample parity: first sample after reset is odd
  logic odd_phase;

  // Gain table 10^(n*0.2/20) in Q2.14, n = 0..31
  function automatic logic [17:0] gain_q(input logic [4:0] n);
    logic [17:0] t [32];
    t = '{18'h04000, 18'h0417e, 18'h04304, 18'h04494, 18'h0462d,
          18'h047cf, 18'h0497b, 18'h04b32, 18'h04cf2, 18'h04ebd,
          18'h05092, 18'h05273, 18'h0545e, 18'h05655, 18'h05858,
          18'h05a67, 18'h05c82, 18'h05eaa, 18'h060de, 18'h06320,
          18'h0656f, 18'h067cc, 18'h06a37, 18'h06cb0, 18'h06f38,
          18'h071cf, 18'h07476, 18'h0772c, 18'h079f3, 18'h07cca,
          18'h07fb2, 18'h082ac};
    gain_q = t[n];
  endfunction : gain_q

  function automatic logic signed [SW-1:0] sat(input logic signed [31:0] v);
    if (v > 32'sd8191)
      sat = 14'sh1fff;
    else if (v < -32'sd8192)
      sat = -14'sh2000;
    else
      sat = v[SW-1:0];
  endfunction : sat

  wire [15:0] cur_reg  = odd_phase ? reg_odd : reg_even;
  wire [4:0]  gain_n   = gain_en ? cur_reg[GAIN_MSB:GAIN_LSB] : 5'h00;
  wire signed [9:0] ofs = ofs_en ? $signed(cur_reg[OFS_MSB:OFS_LSB])
                                 : 10'sh000;
  wire signed [31:0] x_ofs = 32'(signed'(fifo_out_data)) - 32'(ofs);
  wire signed [49:0] prod  = 50'(x_ofs) * 50'(signed'({1'b0, gain_q(gain_n)}));
  wire signed [SW-1:0] corr = sat(32'(prod >>> 14));

  // High-pass filter: y = x - dc, dc += (x - dc) >> k, dc in 16 frac bits
  logic signed [31:0] dc_acc;
  wire [3:0]  k_raw  = reg_pat[K_MSB:K_LSB];
  wire [3:0]  k_eff  = (k_raw < K_MIN) ? K_MIN :
                       (k_raw > K_MAX) ? K_MAX : k_raw;
  wire signed [31:0] x_fix  = 32'(signed'(corr)) <<< 16;
  wire signed [31:0] hp_fix = x_fix - dc_acc;
  wire signed [31:0] next_dc = dc_acc + (hp_fix >>> k_eff);
  wire signed [31:0] hp_rnd  = reg_pat[ROUND_BIT] ?
                               (hp_fix + 32'sh8000) : hp_fix;
  wire signed [SW-1:0] hp_out = sat(hp_rnd >>> 16);
  wire hpf_on = reg_pat[HPF_EN_BIT];
  wire signed [SW-1:0] data_final = hpf_on ? hp_out : corr;

  // PRBS-15 generator per output word
  logic [15:0] prbs;
  wire  next_bit = prbs[14] ^ prbs[13];
  wire [15:0] next_prbs = {prbs[14:0], next_bit};

  function automatic logic [SW-1:0] pattern(input logic [2:0] code,
                                            input logic [SW-1:0] d,
                                            input logic [15:0] p);
    case (code)
      3'h0:    pattern = d;
      3'h1:    pattern = '0;
      3'h2:    pattern = '1;
      3'h3:    pattern = 14'h2aaa;
      3'h4:    pattern = 14'h1555;
      3'h5:    pattern = p[SW-1:0];
      3'h6:    pattern = 14'h2000;
      default: pattern = d;
    endcase
  endfunction : pattern

  function automatic logic [SW-1:0] lane_sel(input logic prbs_bit,
                                             input logic [2:0] code,
                                             input logic [SW-1:0] d,
                                             input logic [15:0] p);
    if (!pat_en)
      lane_sel = d;
    else if (prbs_bit)
      lane_sel = p[SW-1:0];
    else
      lane_sel = pattern(code, d, p);
  endfunction : lane_sel

  wire [SW-1:0] d_u = data_final;
  wire [SW-1:0] next_l1 = lane_sel(reg_pat[PRBS_MSB],
                                   reg_pat[PAT1_MSB:PAT1_LSB], d_u, prbs);
  wire [SW-1:0] next_l2 = lane_sel(reg_pat[PRBS_MSB-1],
                                   reg_pat[PAT2_MSB:PAT2_LSB], d_u, prbs);
  wire [SW-1:0] next_l3 = lane_sel(reg_pat[PRBS_MSB-2], 3'h0, d_u, prbs);
  wire [SW-1:0] next_l4 = lane_sel(reg_pat[PRBS_LSB], 3'h0, d_u, prbs);

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      odd_phase      <= 1'b1;
      dc_acc         <= '0;
      prbs           <= PRBS_SEED;
      lane1_out      <= '0;
      lane2_out      <= '0;
      lane3_out      <= '0;
      lane4_out      <= '0;
      lane_valid_out <= 1'b0;
    end
    else
    begin
      if (take)
      begin
        odd_phase <= !odd_phase;
        dc_acc    <= hpf_on ? next_dc : '0;
        prbs      <= next_prbs;
        lane1_out <= next_l1;
        lane2_out <= next_l2;
        lane3_out <= next_l3;
        lane4_out <= next_l4;
      end
      if (take)
        lane_valid_out <= 1'b1;
      else if (lane_ready_in)
        lane_valid_out <= 1'b0;
    end
  end
endmodule : agohp_top
`default_nettype wire

// ### rtl/agohp_pkg.sv
// Package of register map, field layout and constants for the gain block
// How it works
// - Gain enabled: odd samples scaled 0.2 dB/count
// - Gain enabled: even samples scaled 0.2 dB/count
// - Offset enabled: subtract odd offset field
// - Offset enabled: subtract even offset field
// - Offset is ten-bit signed, 14-bit LSB
// - Pattern select: PRBS on enabled lanes 1-4
// - Pattern select: lanes 1-2 use codes
// - Rounding clear: truncate filter output
// - Rounding set: round filter output
// - Filter corner k from four-bit field
// - Filter only while enable set, reset off
package agohp_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          SAMPLE_W        = 14;
  localparam logic [7:0]  IDX_ODD         = 8'h13;
  localparam logic [7:0]  IDX_EVEN        = 8'h14;
  localparam logic [7:0]  IDX_PAT         = 8'h15;
  localparam logic [7:0]  IDX_GLOBAL      = 8'h20;
  localparam logic [7:0]  IDX_STATUS      = 8'h21;
  localparam logic [15:0] RESET_VAL       = 16'h0000;
  localparam int          GAIN_MSB        = 15;
  localparam int          GAIN_LSB        = 11;
  localparam int          OFS_MSB         = 9;
  localparam int          OFS_LSB         = 0;
  localparam int          PRBS_MSB        = 15;
  localparam int          PRBS_LSB        = 12;
  localparam int          PAT1_MSB        = 11;
  localparam int          PAT1_LSB        = 9;
  localparam int          PAT2_MSB        = 8;
  localparam int          PAT2_LSB        = 6;
  localparam int          ROUND_BIT       = 5;
  localparam int          K_MSB           = 4;
  localparam int          K_LSB           = 1;
  localparam int          HPF_EN_BIT      = 0;
  localparam int          GLB_GAIN_BIT    = 0;
  localparam int          GLB_OFS_BIT     = 1;
  localparam int          GLB_PAT_BIT     = 2;
  localparam logic [3:0]  K_MIN           = 4'h2;
  localparam logic [3:0]  K_MAX           = 4'ha;
  localparam int          FIFO_DEPTH      = 8;
  localparam logic [15:0] PRBS_SEED       = 16'h7fff;
  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b00,
    BUS_DONE = 2'b01
  } agohp_bus_t;
endpackage : agohp_pkg

// ### rtl/agohp_fifo.sv
// Synchronous valid/ready FIFO held in flip-flops
`timescale 1ns/1ns
`default_nettype none
module agohp_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = wr_valid_in && wr_ready_out;
  wire              pop  = rd_valid_out && rd_ready_in;
  assign wr_ready_out = (count != AW'(0) + (AW+1)'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign rd_data_out  = mem[rd_ptr];
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (push)
      mem[wr_ptr] <= wr_data_in;
  end
endmodule : agohp_fifo
`default_nettype wire

// ### bench/agohp_assertions.sv
// Checker for the register bus and sample stream of the gain block
`timescale 1ns/1ns
`default_nettype none
module agohp_checker
  import agohp_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic        sys_clk_in,
  input wire logic        reset_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        sample_ready_out,
  input wire logic [13:0] lane1_out,
  input wire logic [13:0] lane4_out,
  input wire logic        lane_valid_out,
  input wire logic        lane_ready_in
);
  logic req;
  logic mapped;
  assign req = avs_read_in | avs_write_in;
  assign mapped = avs_address_in inside {8'h13, 8'h14, 8'h15, 8'h20, 8'h21};
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  a_req_answer: assert property ((req && !$past(req)) |=> !avs_waitrequest_out)
    else $error("request not answered in one cycle");
  a_ack_cause: assert property (!avs_waitrequest_out |-> req && $past(req))
    else $error("acknowledge without request");
  a_idle_wait: assert property (!req |-> avs_waitrequest_out)
    else $error("waitrequest low while idle");
  a_upper_zero: assert property ((!avs_waitrequest_out && avs_read_in)
    |-> avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property ((!avs_waitrequest_out && avs_read_in
    && !mapped) |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_lane_hold: assert property ((lane_valid_out && !lane_ready_in)
    |=> lane_valid_out && $stable(lane1_out) && $stable(lane4_out))
    else $error("lane word changed while stalled");
  a_full_stall: assert property (!sample_ready_out
    |-> $past(lane_valid_out && !lane_ready_in))
    else $error("input refused without output stall");
endmodule : agohp_checker
bind agohp_top agohp_checker #(.DEPTH(DEPTH)) agohp_checker_inst (.*);
`default_nettype wire

// ### bench/agohp_top_tb_top.sv
// Self-checking bench for the gain block
`timescale 1ns/1ns
`default_nettype none
module agohp_top_tb_top;
  import agohp_pkg::*;
  logic        sys_clk_in, reset_in, avs_read_in, avs_write_in;
  logic        sample_valid_in, lane_ready_in, avs_waitrequest_out;
  logic        sample_ready_out, lane_valid_out;
  logic [7:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rnd, rd;
  logic [3:0]  avs_byteenable_in;
  logic [13:0] sample_in, lane1_out, lane2_out, lane3_out, lane4_out;
  logic [13:0] l1, l2, l3, l4, x, p, q[$];
  logic [15:0] r13, r14;
  int          err_total, checked, n, d;
  agohp_top agohp_top_inst (.*);
  initial
  begin
    sys_clk_in = 0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [13:0] corr(input logic [13:0] v14,
    input logic [15:0] r, input logic ge, input logic oe);
    real v;
    v = $signed(v14) - (oe ? $signed(r[9:0]) : 0);
    v = v * 10.0 ** (ge ? r[15:11] * 0.01 : 0.0);
    if (v > 8191.0) v = 8191.0;
    if (v < -8192.0) v = -8192.0;
    return 14'(int'(v));
  endfunction : corr
  function automatic logic [13:0] pat(input logic [2:0] c, input logic [13:0] v);
    case (c)
      3'd1: return 14'h0000;
      3'd2: return 14'h3fff;
      3'd3: return 14'h2aaa;
      3'd4: return 14'h1555;
      3'd6: return 14'h2000;
      default: return v;
    endcase
  endfunction : pat
  task chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      $display("[FAIL] %0t %s", $time, msg);
      err_total++;
    end
  endtask : chk
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] dt);
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= dt;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 0;
    avs_read_in <= 0;
    @(posedge sys_clk_in);
  endtask : bus
  task xfer(input logic [13:0] v);
    x = v;
    sample_in <= v;
    sample_valid_in <= 1;
    do @(posedge sys_clk_in); while (sample_ready_out !== 1'b1);
    sample_valid_in <= 0;
    do @(posedge sys_clk_in); while (lane_valid_out !== 1'b1);
    {l1, l2, l3, l4} = {lane1_out, lane2_out, lane3_out, lane4_out};
    n++;
  endtask : xfer
  task rst();
    reset_in <= 1;
    repeat (3) @(posedge sys_clk_in);
    reset_in <= 0;
    n = 0;
    @(posedge sys_clk_in);
  endtask : rst
  task finish_test();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    {avs_read_in, avs_write_in, sample_valid_in, avs_address_in} = 0;
    {avs_writedata_in, sample_in} = 0;
    reset_in = 1;
    lane_ready_in = 1;
    avs_byteenable_in = 4'hf;
    rnd = 32'h29516687;
    rst();
    for (int a = 8'h13; a <= 8'h15; a++)
    begin
      bus(0, 8'(a), 0);
      chk(rd === 32'h0, "reset value");
      rnd = lfsr(rnd);
      bus(1, 8'(a), rnd);
      bus(0, 8'(a), 0);
      chk(rd === {16'h0, rnd[15:0]}, "readback");
    end
    bus(1, 8'h13, 32'h1234);
    avs_byteenable_in <= 4'h1;
    bus(1, 8'h13, 32'hffff);
    avs_byteenable_in <= 4'hf;
    bus(0, 8'h13, 0);
    chk(rd === 32'h12ff, "byte enable");
    bus(1, 8'h30, 32'hffff);
    bus(0, 8'h30, 0);
    chk(rd === 32'h0, "unmapped read");
    bus(1, 8'h15, 0);
    for (int j = 0; j < 4; j++)
    begin
      bus(1, 8'h20, 32'(j));
      r13 = j < 2 ? 16'h0200 : rnd[15:0];
      r14 = j < 2 ? 16'hf9ff : rnd[31:16];
      bus(1, 8'h13, {16'h0, r13 & 16'hfbff});
      bus(1, 8'h14, {16'h0, r14 & 16'hfbff});
      repeat (8)
      begin
        rnd = lfsr(rnd);
        xfer(rnd[13:0]);
        d = $signed(l1) - $signed(corr(x, n[0] ? r13 : r14, j[0], j[1]));
        chk(d >= -2 && d <= 2, "corrected sample");
      end
    end
    bus(1, 8'h20, 32'h4);
    for (int c = 0; c < 8; c++)
    begin
      bus(1, 8'h15, 32'(c * 9 * 64));
      rnd = lfsr(rnd);
      xfer(rnd[13:0]);
      chk(l2 === l1 && (c == 5 || l1 === pat(3'(c), x)), "pattern");
    end
    bus(1, 8'h15, 32'ha000);
    xfer(14'h0123);
    p = l1;
    xfer(14'h0123);
    chk(l1 !== p && l3 !== p && l2 === x && l4 === x, "prbs lanes");
    rst();
    bus(1, 8'h15, 32'h15);
    repeat (20) xfer(14'd4000);
    chk($signed(l1) > 3000, "slow corner");
    bus(1, 8'h15, 32'h5);
    repeat (30) xfer(14'd4000);
    chk($signed(l1) < 100 && $signed(l1) > -100, "fast");
    bus(1, 8'h15, 32'h0);
    xfer(14'd4000);
    chk(l1 === x, "filter off");
    lane_ready_in <= 0;
    sample_valid_in <= 1;
    for (int i = 0; i < 20 && sample_ready_out !== 1'b0; i++)
    begin
      rnd = lfsr(rnd);
      sample_in <= rnd[13:0];
      @(posedge sys_clk_in);
      if (sample_ready_out === 1'b1) q.push_back(sample_in);
    end
    sample_valid_in <= 0;
    chk(q.size() >= FIFO_DEPTH && q.size() <= FIFO_DEPTH + 1, "fill count");
    lane_ready_in <= 1;
    while (q.size() > 0)
    begin
      @(posedge sys_clk_in);
      if (lane_valid_out === 1'b1) chk(lane1_out === q.pop_front(), "drain");
    end
    finish_test();
  end
  initial
  begin
    #(40 * 30000);
    err_total++;
    finish_test();
  end
endmodule : agohp_top_tb_top
`default_nettype wire
